// ===== imx_exec.sv
`timescale 1ns/1ps
module imx_exec (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        reset_n,
	// decoded instruction
	input  wire logic        op_valid,
	input  wire logic [2:0]  op_code,
	input  wire logic        ptr_sel,
	input  wire logic [1:0]  pointer_update_mode,
	input  wire logic [5:0]  offset_k,
	input  wire logic [7:0]  accumulator,
	input  wire logic [7:0]  status_in,
	// pointer loading by other instructions
	input  wire logic        ptr_load,
	input  wire logic [15:0] ptr_load_value,
	// data memory write port
	output logic             mem_we,
	output logic [15:0]      mem_addr,
	output logic [7:0]       mem_wdata,
	// core state
	output logic [15:0]      indirect_pointer_0,
	output logic [15:0]      indirect_pointer_1,
	output logic [7:0]       option_reg,
	output logic [7:0]       status_out,
	output logic             software_reset_indicator,
	output logic             device_reset_req
);
	// ----------------------------------------
	// local state
	// ----------------------------------------
	logic [15:0]            ptr [2];
	logic [15:0]            next_ptr [2];
	logic                   next_mem_we;
	logic [15:0]            next_mem_addr;
	logic [7:0]             next_mem_wdata;
	logic [7:0]             next_option_reg;
	logic [7:0]             next_status_out;
	logic                   next_sri;
	logic                   next_reset_req;
	logic [2:0]             rst_cnt;
	logic [2:0]             next_rst_cnt;
	imx_pkg::imx_state_type state;
	imx_pkg::imx_state_type next_state;
	logic [15:0]            cur;
	logic [15:0]            stepped;
	logic [15:0]            offs;
	logic                   take;
	logic                   take_move;
	logic                   take_offset;
	logic                   take_window;
	logic                   take_option;
	logic                   take_reset;

	// ----------------------------------------
	// instruction decode
	// ----------------------------------------
	// nothing is taken while the soft reset sequence runs, so no
	// op can slip in on the last cycle of the reset request
	always_comb begin
		take        = op_valid && (state == imx_pkg::IMX_ST_RUN);
		take_move   = 1'b0;
		take_offset = 1'b0;
		take_window = 1'b0;
		take_option = 1'b0;
		take_reset  = 1'b0;
		if (take) begin
			case (op_code)
			imx_pkg::IMX_OP_MOVE_IND: begin
				take_move = 1'b1;
			end
			imx_pkg::IMX_OP_MOVE_OFS: begin
				take_offset = 1'b1;
			end
			imx_pkg::IMX_OP_WINDOW: begin
				take_window = 1'b1;
			end
			imx_pkg::IMX_OP_OPTION: begin
				take_option = 1'b1;
			end
			imx_pkg::IMX_OP_RESET: begin
				take_reset = 1'b1;
			end
			default: ;
			endcase
		end
	end

	// ----------------------------------------
	// address arithmetic
	// ----------------------------------------
	// one adder serves all four modes; bit 0 picks the direction
	always_comb begin
		cur = ptr[ptr_sel];
		// 16-bit add wraps past ffff and below 0000 on its own
		if (pointer_update_mode[0])
			stepped = cur - 16'h0001;
		else
			stepped = cur + 16'h0001;
		offs = {{10{offset_k[5]}}, offset_k}; // sign extend
	end

	// ----------------------------------------
	// pointers
	// ----------------------------------------
	// a move wins over a same-cycle load; the load would be lost
	// silently, so callers must not overlap the two
	always_comb begin
		next_ptr[0] = ptr[0];
		next_ptr[1] = ptr[1];
		if (take_move)
			next_ptr[ptr_sel] = stepped;
		else if (ptr_load)
			next_ptr[ptr_sel] = ptr_load_value;
	end

	// one flop bank per pointer
	for (genvar gi = 0; gi < 2; gi++) begin : g_ptr
		always_ff @(posedge mclk or negedge reset_n) begin
			if (!reset_n)
				ptr[gi] <= imx_pkg::IMX_PTR_RST;
			else
				ptr[gi] <= next_ptr[gi];
		end
	end

	// pointer outputs come straight from the pointer flops
	always_comb begin
		indirect_pointer_0 = ptr[0];
		indirect_pointer_1 = ptr[1];
	end

	// ----------------------------------------
	// data memory write port
	// ----------------------------------------
	// address and data hold after a write; only the strobe drops
	always_comb begin
		next_mem_we    = 1'b0;
		next_mem_addr  = mem_addr;
		next_mem_wdata = mem_wdata;
		if (take_move) begin
			next_mem_we    = 1'b1;
			next_mem_wdata = accumulator;
			// pre modes use the updated address
			if (pointer_update_mode[1])
				next_mem_addr = cur;
			else
				next_mem_addr = stepped;
		end else if (take_offset) begin
			next_mem_we    = 1'b1;
			next_mem_wdata = accumulator;
			next_mem_addr  = cur + offs;     // pointer kept
		end else if (take_window) begin
			// window has no storage, goes to pointer target
			next_mem_we    = 1'b1;
			next_mem_wdata = accumulator;
			next_mem_addr  = cur;
		end
	end

	// write port flops
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			mem_we    <= 1'b0;
			mem_addr  <= imx_pkg::IMX_PTR_RST;
			mem_wdata <= 8'h00;
		end else begin
			mem_we    <= next_mem_we;
			mem_addr  <= next_mem_addr;
			mem_wdata <= next_mem_wdata;
		end
	end

	// ----------------------------------------
	// option register and flags
	// ----------------------------------------
	// flags are only carried, never touched by pointer steps
	always_comb begin
		next_option_reg = option_reg;
		next_status_out = status_in;
		if (take_option)
			next_option_reg = accumulator;
	end

	// option and flag flops
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			option_reg <= imx_pkg::IMX_OPTION_RST;
			status_out <= imx_pkg::IMX_STATUS_RST;
		end else begin
			option_reg <= next_option_reg;
			status_out <= next_status_out;
		end
	end

	// ----------------------------------------
	// soft reset sequencer
	// ----------------------------------------
	// the request stays up for the whole count, and the state
	// leaves reset only when the request drops
	always_comb begin
		next_sri       = software_reset_indicator;
		next_reset_req = 1'b0;
		next_state     = state;
		next_rst_cnt   = rst_cnt;
		case (state)
		imx_pkg::IMX_ST_RUN: begin
			if (take_reset) begin
				next_sri       = 1'b0;
				next_reset_req = 1'b1;
				next_state     = imx_pkg::IMX_ST_RESET;
				next_rst_cnt   = 3'(imx_pkg::IMX_RESET_CYCLES);
			end
		end
		imx_pkg::IMX_ST_RESET: begin
			next_rst_cnt = rst_cnt - 3'h1;
			if (rst_cnt == 3'h1)
				next_state = imx_pkg::IMX_ST_RUN;
			else
				next_reset_req = 1'b1;
		end
		default: begin
			next_state = imx_pkg::IMX_ST_RUN;
		end
		endcase
	end

	// indicator resets to 1 on power-up; only the reset op clears it
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			software_reset_indicator <= 1'b1;
			device_reset_req         <= 1'b0;
			state                    <= imx_pkg::IMX_ST_RUN;
			rst_cnt                  <= 3'h0;
		end else begin
			software_reset_indicator <= next_sri;
			device_reset_req         <= next_reset_req;
			state                    <= next_state;
			rst_cnt                  <= next_rst_cnt;
		end
	end
endmodule // imx_exec

// ===== imx_exec_checker.sv
`timescale 1ns/1ps
// ----
// execution checks
// ----
module imx_exec_checker (
	input logic        mclk, reset_n, op_valid, ptr_sel, mem_we,
	input logic [2:0]  op_code,
	input logic [1:0]  pointer_update_mode,
	input logic [5:0]  offset_k,
	input logic [7:0]  accumulator, status_in, status_out,
	input logic [7:0]  option_reg, mem_wdata,
	input logic [15:0] mem_addr, indirect_pointer_0,
	input logic        software_reset_indicator, device_reset_req,
	input logic        ptr_load
);
	// pointer checks watch pointer 0 only, to stay short
	wire        go = op_valid && !device_reset_req;
	wire        g0 = go && !ptr_sel;
	wire [1:0]  md = pointer_update_mode;
	wire [15:0] p = indirect_pointer_0;
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	AST_DATA: assert property (go && op_code == 3'h1 |=>
		mem_we && mem_wdata == $past(accumulator)) else $error("data");
	AST_PRE_INC: assert property (g0 && op_code == 3'h1 && md == 2'h0
		|=> mem_addr == $past(p) + 16'h1 && p == mem_addr) else $error("inc");
	AST_POST_DEC: assert property (g0 && op_code == 3'h1 && md == 2'h3
		|=> mem_addr == $past(p) && p == $past(p) - 16'h1) else $error("dec");
	AST_WINDOW: assert property (g0 && !ptr_load && op_code == 3'h5 |=>
		mem_we && mem_addr == $past(p) && $stable(p)) else $error("window");
	AST_OFFSET: assert property (g0 && !ptr_load && op_code == 3'h2 |=>
		$stable(p) &&
		mem_addr == $past(p) + {{10{$past(offset_k[5])}}, $past(offset_k)})
		else $error("offset");
	AST_FLAGS: assert property (go && op_code == 3'h1 |=>
		status_out == $past(status_in)) else $error("flags");
	AST_OPTION: assert property (go && op_code == 3'h3 |=>
		option_reg == $past(accumulator)) else $error("option");
	AST_RESET: assert property (go && op_code == 3'h4 |=>
		device_reset_req[*4] ##1 !device_reset_req) else $error("reset");
	AST_IND: assert property (go && op_code == 3'h4 |=>
		!software_reset_indicator) else $error("indicator");
	cover property (g0 && op_code == 3'h2);
	cover property (go && op_code == 3'h4);
	cover property (op_valid && device_reset_req);
endmodule // imx_exec_checker
bind imx_exec imx_exec_checker i_chk (.*);

// ===== imx_pkg.sv
package imx_pkg;
	// ----------------------------------------
	// widths and reset values
	// ----------------------------------------
	localparam int unsigned IMX_DATA_W      = 8;
	localparam int unsigned IMX_ADDR_W      = 16;
	localparam int unsigned IMX_OFFSET_W    = 6;
	localparam int unsigned IMX_NUM_PTR     = 2;
	localparam logic [7:0]  IMX_OPTION_RST  = 8'hff;
	localparam logic [7:0]  IMX_STATUS_RST  = 8'h00;
	localparam logic [15:0] IMX_PTR_RST     = 16'h0000;
	// software reset pulse length in cycles
	localparam int unsigned IMX_RESET_CYCLES = 4;

	// ----------------------------------------
	// operations and pointer update modes
	// ----------------------------------------
	typedef enum logic [2:0] {
		IMX_OP_NONE     = 3'b000,
		IMX_OP_MOVE_IND = 3'b001,
		IMX_OP_MOVE_OFS = 3'b010,
		IMX_OP_OPTION   = 3'b011,
		IMX_OP_RESET    = 3'b100,
		IMX_OP_WINDOW   = 3'b101
	} imx_op_type;

	typedef enum logic [1:0] {
		IMX_MODE_PRE_INC  = 2'b00,
		IMX_MODE_PRE_DEC  = 2'b01,
		IMX_MODE_POST_INC = 2'b10,
		IMX_MODE_POST_DEC = 2'b11
	} imx_mode_type;

	typedef enum logic [1:0] {
		IMX_ST_RUN   = 2'b00,
		IMX_ST_RESET = 2'b01
	} imx_state_type;
endpackage

// ===== tb_indirect_move_misc_instr_exec.sv
`timescale 1ns/1ps
module tb_indirect_move_misc_instr_exec;
	logic        mclk = 1'h0, reset_n = 1'h0, op_valid = 1'h0;
	logic        ptr_sel = 1'h0, ptr_load = 1'h0;
	logic [2:0]  op_code = 3'h0;
	logic [1:0]  pointer_update_mode = 2'h0;
	logic [5:0]  offset_k = 6'h0;
	logic [7:0]  accumulator = 8'h0, status_in = 8'h5a;
	logic [15:0] ptr_load_value = 16'h0;
	logic        mem_we, software_reset_indicator, device_reset_req;
	logic [15:0] mem_addr, indirect_pointer_0, indirect_pointer_1;
	logic [7:0]  mem_wdata, option_reg, status_out;
	int          bad_count = 0, tests_run = 0;
	imx_exec i_dut (.*);
	// free running clock
	initial forever #25 mclk = ~mclk;
	task chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task give_verdict;
		if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// idle cycle first, so strobes never change twice in one step
	task op(input logic [2:0] c, input logic [1:0] m, input logic [7:0] w);
		@(posedge mclk) #1;
		op_code = c;
		pointer_update_mode = m;
		accumulator = w;
		op_valid = 1'h1;
		@(posedge mclk) #1;
		op_valid = 1'h0;
	endtask
	task load(input logic s, input logic [15:0] v);
		@(posedge mclk) #1;
		ptr_sel = s;
		ptr_load_value = v;
		ptr_load = 1'h1;
		@(posedge mclk) #1;
		ptr_load = 1'h0;
	endtask
	// every mode on pointer 1 across the wrap point
	task t_modes;
		logic [15:0] ea [4] = '{16'h0, 16'hffff, 16'hffff, 16'h0};
		logic [15:0] ep [4] = '{16'h0, 16'hffff, 16'h0, 16'hffff};
		load(1'h1, 16'hffff);
		for (int i = 0; i < 4; i++) begin
			op(3'h1, 2'(i), 8'h30 + 8'(i));
			chk(mem_addr, ea[i]);
			chk(indirect_pointer_1, ep[i]);
			chk({mem_we, mem_wdata}, {1'h1, 8'h30 + 8'(i)});
			chk(status_out, 8'h5a);
		end
	endtask
	// most negative offset wraps below zero
	task t_offset;
		load(1'h0, 16'h0010);
		offset_k = 6'h20;
		op(3'h2, 2'h0, 8'h11);
		chk(mem_addr, 16'hfff0);
		chk(indirect_pointer_0, 16'h0010);
		op(3'h5, 2'h0, 8'h22);
		chk({mem_addr[7:0], mem_wdata}, 16'h1022);
	endtask
	// option load, then soft reset refusing a later op
	task t_soft;
		op(3'h3, 2'h0, 8'h4f);
		chk(option_reg, 8'h4f);
		op(3'h4, 2'h0, 8'h4f);
		chk({device_reset_req, software_reset_indicator}, 2'h2);
		op(3'h3, 2'h0, 8'h99);
		chk(option_reg, 8'h4f);
		repeat (2) @(posedge mclk) #1;
		chk(device_reset_req, 1'h0);
		reset_n = 1'h0;
		@(posedge mclk) #1;
		reset_n = 1'h1;
		chk(software_reset_indicator, 1'h1);
	endtask
	// main sequence
	initial begin
		repeat (4) @(posedge mclk);
		#1 reset_n = 1'h1;
		chk({software_reset_indicator, option_reg}, 9'h1ff);
		t_modes;
		t_offset;
		t_soft;
		give_verdict;
	end
	// watchdog: the tests need well under 100 cycles
	initial begin
		#20000;
		bad_count++;
		give_verdict;
	end
endmodule // tb_indirect_move_misc_instr_exec
